// ---- rtl/llcr_pkg.sv ----
/*
  Package for the link control register block: offset, bit positions,
  reset values and timing counts.
  Assumes a single 250 MHz core clock.
*/
package llcr_pkg;
  localparam logic [7:0] LLCR_CTRL_OFFSET = 8'h08;
  // Bit numbers count from the most significant bit (bit 00 = [31])
  localparam int LLCR_SOFT_RESET_POS = 31 - 0;
  localparam int LLCR_PAGE_POS = 31 - 3;
  localparam int LLCR_BUSY_POS = 31 - 4;
  localparam int LLCR_TRANSMIT_ENABLE_BIT_POS = 31 - 5;
  localparam int LLCR_RECEIVE_ENABLE_BIT_POS = 31 - 6;
  localparam int LLCR_TXRST_POS = 31 - 10;
  localparam int LLCR_RXRST_POS = 31 - 11;
  localparam int LLCR_LHOLD_POS = 31 - 14;
  localparam int LLCR_SIDCLR_POS = 31 - 23;
  localparam int LLCR_POWER_ON_SWITCH_OUT_POS = 31 - 27;
  localparam logic [31:0] LLCR_CTRL_RESET = 32'h0600_0000;
  localparam logic [31:0] LLCR_STORED_MASK = 32'h9e02_0010;
  localparam logic [3:0] LLCR_HOLD_SHORT = 4'h1;
  localparam logic [3:0] LLCR_HOLD_LONG = 4'ha;
endpackage

// ---- rtl/llcr_pulse.sv ----
/*
  Pulse generator: pulse repeats trigger one cycle later and stays high for as many cycles as trigger was high.
  Assumes synchronous inputs on the core clock.
*/
`timescale 1ns/1ps
module llcr_pulse (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trigger,
  output logic pulse
);
  logic next_pulse;

  always_comb begin
    next_pulse = trigger;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= next_pulse;
    end
  end
endmodule

// ---- rtl/llcr_top.sv ----
/*
  Link layer control register with its control outputs.
  Assumes a plain register port with read data one cycle after the strobe.
*/
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module llcr_top
  import llcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bus_reset,
  input wire logic selfid_error_event,
  input wire logic rx_buffer_busy,
  output logic selfid_error_flag,
  output logic soft_reset_req,
  output logic data_page_select,
  output logic busy_ack_force,
  output logic tx_allowed,
  output logic rx_allowed,
  output logic tx_reset_pulse,
  output logic rx_reset_pulse,
  output logic [3:0] grant_hold_cycles,
  output logic power_on_switch_out
);
  logic rst_meta, rst_n;
  logic [31:0] ctrl, next_ctrl;
  logic next_flag;
  logic [31:0] next_rdata;
  logic ctrl_wr;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign ctrl_wr = reg_wr && (reg_addr == LLCR_CTRL_OFFSET);

  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl = reg_wdata & LLCR_STORED_MASK;
    end
    // bus_reset intentionally does not touch the enables
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= LLCR_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Self-clearing strobes: one cycle after the write
  llcr_pulse u_txrst (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .trigger(ctrl_wr && reg_wdata[LLCR_TXRST_POS]), .pulse(tx_reset_pulse));
  llcr_pulse u_rxrst (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .trigger(ctrl_wr && reg_wdata[LLCR_RXRST_POS]), .pulse(rx_reset_pulse));
  logic sid_clear;
  llcr_pulse u_sidclr (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .trigger(ctrl_wr && reg_wdata[LLCR_SIDCLR_POS]), .pulse(sid_clear));

  always_comb begin
    next_flag = selfid_error_flag;
    if (sid_clear) begin
      next_flag = 1'b0;
    end
    if (selfid_error_event) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selfid_error_flag <= 1'b0;
    end else begin
      selfid_error_flag <= next_flag;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd && reg_addr == LLCR_CTRL_OFFSET) begin
      next_rdata = ctrl;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  assign soft_reset_req = ctrl[LLCR_SOFT_RESET_POS];
  assign data_page_select = ctrl[LLCR_PAGE_POS];
  assign busy_ack_force = ctrl[LLCR_BUSY_POS] | rx_buffer_busy;
  assign tx_allowed = ctrl[LLCR_TRANSMIT_ENABLE_BIT_POS];
  assign rx_allowed = ctrl[LLCR_RECEIVE_ENABLE_BIT_POS];
  assign grant_hold_cycles = ctrl[LLCR_LHOLD_POS] ? LLCR_HOLD_LONG
                                                   : LLCR_HOLD_SHORT;
  assign power_on_switch_out = ctrl[LLCR_POWER_ON_SWITCH_OUT_POS];

  // Register contents follow the bus only
  a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_wr |=> ctrl == ($past(reg_wdata) & LLCR_STORED_MASK))
    else $error("control word not stored");

  a_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(ctrl))
    else $error("control word moved without write");

  a_unmapped_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr != LLCR_CTRL_OFFSET) |=> $stable(ctrl))
    else $error("unmapped write reached control word");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl & ~LLCR_STORED_MASK) == 32'h0)
    else $error("reserved bit set");

  a_strobe_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[LLCR_TXRST_POS] && !ctrl[LLCR_RXRST_POS])
    else $error("unit reset bit kept");

  a_sidclr_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[LLCR_SIDCLR_POS])
    else $error("self-ID clear bit kept");

  // Read port
  a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == LLCR_CTRL_OFFSET && !reg_wr) |=> reg_rdata == $past(ctrl))
    else $error("read data wrong");

  a_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr != LLCR_CTRL_OFFSET) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  a_read_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rdata & ~LLCR_STORED_MASK) == 32'h0)
    else $error("reserved bit read back");

  // Control outputs
  a_soft_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_wr |=> soft_reset_req == $past(reg_wdata[LLCR_SOFT_RESET_POS]))
    else $error("soft reset request mismatch");

  a_soft_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(soft_reset_req))
    else $error("soft reset request moved");

  a_page_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_wr |=> data_page_select == $past(reg_wdata[LLCR_PAGE_POS]))
    else $error("page select mismatch");

  a_page_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(data_page_select))
    else $error("page select moved");

  a_busy_normal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[LLCR_BUSY_POS] |-> busy_ack_force == rx_buffer_busy)
    else $error("normal busy policy broken");

  a_busy_forced: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[LLCR_BUSY_POS] |-> busy_ack_force)
    else $error("forced busy missing");

  a_busy_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && reg_wdata[LLCR_BUSY_POS]) |=> busy_ack_force)
    else $error("busy policy write ignored");

  a_tx_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_wr |=> tx_allowed == $past(reg_wdata[LLCR_TRANSMIT_ENABLE_BIT_POS]))
    else $error("transmit enable mismatch");

  a_tx_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(tx_allowed))
    else $error("transmit enable moved");

  a_rx_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_wr |=> rx_allowed == $past(reg_wdata[LLCR_RECEIVE_ENABLE_BIT_POS]))
    else $error("receive enable mismatch");

  a_rx_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(rx_allowed))
    else $error("receive enable moved");

  a_receive_enable_bit_bus_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_reset && !ctrl_wr) |=> $stable(rx_allowed))
    else $error("rx enable moved on bus reset");

  a_hold_long: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[LLCR_LHOLD_POS] |-> grant_hold_cycles == 4'ha)
    else $error("long hold not ten");

  a_hold_short: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[LLCR_LHOLD_POS] |-> grant_hold_cycles == LLCR_HOLD_SHORT)
    else $error("short hold wrong");

  a_hold_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && reg_wdata[LLCR_LHOLD_POS]) |=> grant_hold_cycles == 4'ha)
    else $error("long hold write ignored");

  a_power_on_switch_out_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_wr |=> power_on_switch_out == $past(reg_wdata[LLCR_POWER_ON_SWITCH_OUT_POS]))
    else $error("power-on pin mismatch");

  a_power_on_switch_out_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(power_on_switch_out))
    else $error("power-on pin moved on its own");

  // Values seen on the first edge after reset
  a_reset_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> ctrl == LLCR_CTRL_RESET)
    else $error("control word reset value wrong");

  a_reset_enables: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> tx_allowed && rx_allowed)
    else $error("enables not set by reset");

  a_reset_outputs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> !soft_reset_req && !data_page_select && !power_on_switch_out &&
      !selfid_error_flag && !tx_reset_pulse && !rx_reset_pulse)
    else $error("output not cleared by reset");

  a_reset_rdata: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> reg_rdata == 32'h0)
    else $error("read data not cleared by reset");

  // Self-clearing strobes
  a_txrst_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_reset_pulse |-> $past(ctrl_wr) && $past(reg_wdata[LLCR_TXRST_POS]))
    else $error("tx reset pulse too long");

  a_txrst_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && reg_wdata[LLCR_TXRST_POS]) |=> tx_reset_pulse)
    else $error("tx reset not pulsed");

  a_txrst_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && !reg_wdata[LLCR_TXRST_POS]) |=> !tx_reset_pulse)
    else $error("tx reset pulsed without request");

  a_rxrst_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_reset_pulse |-> $past(ctrl_wr) && $past(reg_wdata[LLCR_RXRST_POS]))
    else $error("rx reset pulse too long");

  a_rxrst_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && reg_wdata[LLCR_RXRST_POS]) |=> rx_reset_pulse)
    else $error("rx reset not pulsed");

  a_rxrst_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && !reg_wdata[LLCR_RXRST_POS]) |=> !rx_reset_pulse)
    else $error("rx reset pulsed without request");

  a_sid_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sid_clear |-> $past(ctrl_wr) && $past(reg_wdata[LLCR_SIDCLR_POS]))
    else $error("self-ID clear without request");

  a_sid_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_wr && reg_wdata[LLCR_SIDCLR_POS] && !selfid_error_event) ##1
      !selfid_error_event |=> !selfid_error_flag)
    else $error("self-ID flag not cleared");

  // Error flag: set wins over clear
  a_sid_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    selfid_error_event |=> selfid_error_flag)
    else $error("self-ID flag not set");

  a_sid_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (selfid_error_flag && !sid_clear) |=> selfid_error_flag)
    else $error("self-ID flag dropped");

  a_sid_flag_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(selfid_error_flag) |-> $past(selfid_error_event))
    else $error("self-ID flag set without error");

  // Main scenarios
  c_tx_reset: cover property (@(posedge sys_clk) disable iff (!rst_n) tx_reset_pulse);
  c_sid_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    selfid_error_flag ##1 sid_clear);
  c_tx_off: cover property (@(posedge sys_clk) disable iff (!rst_n) !tx_allowed);
  c_long_hold: cover property (@(posedge sys_clk) disable iff (!rst_n)
    grant_hold_cycles == LLCR_HOLD_LONG);
  c_rx_off_bus_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bus_reset && !rx_allowed);
endmodule

// ---- test/llcr_tb.sv ----
/*
  Self-checking bench for the link control register: register port traffic
  and the control pins. Assumes llcr_top with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module testbench import llcr_pkg::*; ;
  logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, bus_reset = 0;
  logic selfid_error_event = 0, rx_buffer_busy = 0, rd_seen = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic selfid_error_flag, soft_reset_req, data_page_select, busy_ack_force;
  logic tx_allowed, rx_allowed, tx_reset_pulse, rx_reset_pulse, power_on_switch_out;
  logic [3:0] grant_hold_cycles;
  logic [9:0] o;
  logic [31:0] exp_q[$];
  int n_fail = 0, checks_done = 0;
  llcr_top llcr_top_inst (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bus_reset, .selfid_error_event, .rx_buffer_busy, .selfid_error_flag,
    .soft_reset_req, .data_page_select, .busy_ack_force, .tx_allowed, .rx_allowed,
    .tx_reset_pulse, .rx_reset_pulse, .grant_hold_cycles, .power_on_switch_out);
  assign o = {soft_reset_req, data_page_select, busy_ack_force, tx_allowed, rx_allowed,
    power_on_switch_out, grant_hold_cycles};
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) ck(reg_rdata, exp_q.pop_front());
  end
  initial begin
    #40000;
    n_fail++;
    stop_test;
  end
  initial begin
    void'($urandom(32'hcc1858f2));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) ck(o, {6'b000110, 4'h1});
    rd(8'h08, LLCR_CTRL_RESET);
    wr(8'h08, 32'hffffffff);
    @(negedge sys_clk) ck({tx_reset_pulse, rx_reset_pulse}, 2'b11);
    @(negedge sys_clk) ck({tx_reset_pulse, rx_reset_pulse}, 2'b00);
    ck(o, {6'b111111, 4'ha});
    rd(8'h08, LLCR_STORED_MASK);
    wr(8'h08, 32'h0);
    @(posedge sys_clk);
    rx_buffer_busy <= 1;
    bus_reset <= 1;
    @(negedge sys_clk) ck(o, {6'b001000, 4'h1});
    @(posedge sys_clk);
    rx_buffer_busy <= 0;
    selfid_error_event <= 1;
    @(posedge sys_clk);
    selfid_error_event <= 0;
    bus_reset <= 0;
    @(negedge sys_clk) ck({busy_ack_force, selfid_error_flag}, 2'b01);
    wr(8'h08, 32'h00000100);
    repeat (2) @(negedge sys_clk);
    ck(selfid_error_flag, 1'b0);
    rd(8'h08, 32'h0);
    wr(8'h0c, 32'hffffffff);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    repeat (8) begin
      d = $urandom;
      wr(8'h08, d);
      rd(8'h08, d & LLCR_STORED_MASK);
      ck(o, {d[31], d[28], d[27], d[26], d[25], d[4], d[17] ? 4'ha : 4'h1});
    end
    @(posedge sys_clk);
    reset_n <= 0;
    @(negedge sys_clk) ck(o, {6'b000110, 4'h1});
    repeat (3) @(posedge sys_clk);
    reset_n <= 1;
    repeat (2) @(posedge sys_clk);
    rd(8'h08, LLCR_CTRL_RESET);
    repeat (4) @(posedge sys_clk);
    stop_test;
  end
endmodule
